/* File: design/dcr_config_bank.sv */
// serial-port configuration register bank of the demodulator
// assumes a boot loader on sys_clk reports results; serial pins are asynchronous
`timescale 1ns/1ps
`include "dcr_consts.svh"

module dcr_config_bank #(
  parameter logic [3:0] DIE_REV = 4'h3 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic rclk_in,
  input wire logic boot_busy,
  input wire logic boot_done,
  input wire logic boot_timeout,
  input wire logic boot_match,
  input wire logic [7:0] boot_csum,
  output logic soft_reset,
  output dcr_pkg::dcr_cfg_s cfg,
  output logic [`DCR_N_COEF*8-1:0] coef_active,
  output logic coef_load
);

  // ==========================================================================
  // reset image and helpers
  function automatic dcr_pkg::dcr_core_s rst_st();
    dcr_pkg::dcr_core_s s;
    s = '0;
    s.phase = dcr_pkg::DCR_IDLE;
    s.coef = `DCR_R_COEF;
    s.coef_act = `DCR_R_COEF;
    s.cfg = '{analog_pin: `DCR_R_APIN, sync_out: `DCR_R_SYNC, mixer: `DCR_R_MIX,
              clk_div: `DCR_R_CLK, dig_pin: `DCR_R_DPIN, core_rst: `DCR_R_CORE};
    s.sdio_oe_n = 1'b1;
    s.sdo_oe_n = 1'b1;
    return s;
  endfunction

  localparam dcr_pkg::dcr_core_s RST_ST = rst_st();

  // setup byte: stored upper nibble with its bit-reversed mirror below
  function automatic logic [7:0] setup_byte(input logic [3:0] u);
    return {u, u[0], u[1], u[2], u[3]};
  endfunction

  // address step for multibyte access
  function automatic logic [14:0] step(input logic [14:0] a, input logic inc);
    return inc ? 15'(a + 15'h0001) : 15'(a - 15'h0001);
  endfunction

  function automatic logic is_coef(input logic [14:0] a);
    return (a >= `DCR_A_COEF_LO) && (a <= `DCR_A_COEF_HI);
  endfunction

  // read mux; unmapped and don't-care bits return zero
  function automatic logic [7:0] rd_reg(input dcr_pkg::dcr_core_s s, input logic [14:0] a);
    logic [7:0] v;
    int idx;
    v = 8'h00;
    idx = int'(a - `DCR_A_COEF_LO);
    if (is_coef(a)) begin
      v = s.coef[idx*8 +: 8];
    end else begin
      case (a)
        `DCR_A_SETUP: v = setup_byte(s.setup);
        `DCR_A_REV: v = {4'h0, DIE_REV};
        `DCR_A_STROBE: v = {6'h00, s.strobe};
        `DCR_A_APIN: v = s.cfg.analog_pin;
        `DCR_A_SYNC: v = s.cfg.sync_out;
        `DCR_A_MIX: v = s.cfg.mixer;
        `DCR_A_CLK: v = s.cfg.clk_div;
        `DCR_A_DPIN: v = s.cfg.dig_pin;
        `DCR_A_CORE: v = s.cfg.core_rst;
        `DCR_A_CSUM: v = s.csum;
        `DCR_A_BSTAT: v = {5'h00, s.bstat};
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  dcr_pkg::dcr_pins_s pins;
  dcr_pkg::dcr_core_s st_q;
  dcr_pkg::dcr_core_s st_d;
  logic wr_en;
  logic byte_done;
  logic [7:0] wr_data;

  dcr_pin_sync u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin),
    .sdi_pin(sdio_in),
    .pins(pins)
  );

  // ==========================================================================
  // serial protocol, register writes, soft reset and pin drive
  always_comb begin
    logic lsb;
    logic [15:0] sr_n;
    logic [14:0] nxt;
    int idx;
    lsb = st_q.setup[`DCR_B_LSB];
    sr_n = 16'h0000;
    nxt = step(st_q.addr, st_q.setup[`DCR_B_INC]);
    idx = int'(st_q.addr - `DCR_A_COEF_LO);
    st_d = st_q;
    st_d.coef_load = 1'b0;
    wr_en = 1'b0;
    byte_done = 1'b0;
    wr_data = 8'h00;
    // the port is shut while the boot loader owns the registers
    if (pins.cs_n || boot_busy) begin
      st_d.phase = dcr_pkg::DCR_IDLE;
      st_d.bit_cnt = 4'h0;
      st_d.rd = 1'b0;
    end else begin
      if (st_q.phase == dcr_pkg::DCR_IDLE) begin
        st_d.phase = dcr_pkg::DCR_INSTR;
      end
      if (pins.sclk_rise) begin
        // msb first shifts left, lsb first shifts right
        sr_n = lsb ? {pins.sdi, st_q.sr[15:1]} : {st_q.sr[14:0], pins.sdi};
        st_d.sr = sr_n;
        st_d.bit_cnt = 4'(st_q.bit_cnt + 4'h1);
        if (st_q.phase != dcr_pkg::DCR_DATA && st_q.bit_cnt == 4'hf) begin
          st_d.phase = dcr_pkg::DCR_DATA;
          st_d.bit_cnt = 4'h0;
          st_d.rd = sr_n[15];
          st_d.addr = sr_n[14:0];
          st_d.tx = rd_reg(st_q, sr_n[14:0]);
        end else if (st_q.phase == dcr_pkg::DCR_DATA && st_q.bit_cnt == 4'h7) begin
          byte_done = 1'b1;
          st_d.bit_cnt = 4'h0;
          st_d.addr = nxt;
          wr_en = ~st_q.rd;
          wr_data = lsb ? sr_n[15:8] : sr_n[7:0];
          if (st_q.rd) begin
            st_d.tx = rd_reg(st_q, nxt);
          end
        end
      end
      // read data leaves on the falling edge, first bit right after the instruction
      if (pins.sclk_fall && st_q.phase == dcr_pkg::DCR_DATA && st_q.rd) begin
        st_d.dout = lsb ? st_q.tx[0] : st_q.tx[7];
        st_d.tx = lsb ? {1'b0, st_q.tx[7:1]} : {st_q.tx[6:0], 1'b0};
      end
    end
    // writes; read-only addresses fall through untouched
    if (wr_en) begin
      if (is_coef(st_q.addr)) begin
        st_d.coef[idx*8 +: 8] = wr_data;
      end else begin
        case (st_q.addr)
          `DCR_A_SETUP: st_d.setup = wr_data[7:4] |
                                     {wr_data[0], wr_data[1], wr_data[2], wr_data[3]};
          `DCR_A_STROBE: st_d.strobe = wr_data[1:0];
          `DCR_A_APIN: st_d.cfg.analog_pin = wr_data & `DCR_M_APIN;
          `DCR_A_SYNC: st_d.cfg.sync_out = wr_data & `DCR_M_SYNC;
          `DCR_A_MIX: st_d.cfg.mixer = wr_data & `DCR_M_MIX;
          `DCR_A_CLK: st_d.cfg.clk_div = wr_data & `DCR_M_CLK;
          `DCR_A_DPIN: st_d.cfg.dig_pin = wr_data & `DCR_M_DPIN;
          `DCR_A_CORE: st_d.cfg.core_rst = wr_data & `DCR_M_CORE;
          default: ;
        endcase
      end
    end
    // coefficient transfer on the strobe leaving zero
    if (st_q.strobe == 2'b00 && st_d.strobe != 2'b00) begin
      st_d.coef_act = st_d.coef;
      st_d.coef_load = 1'b1;
    end
    // soft reset pins setup to its reset bit alone and strobe, coefficients and configuration bytes to defaults until the host clears it
    if (st_d.setup[`DCR_B_SRST]) begin
      st_d.setup = 4'h8;
      st_d.strobe = 2'b00;
      st_d.coef = RST_ST.coef;
      st_d.coef_act = RST_ST.coef_act;
      st_d.cfg = RST_ST.cfg;
      st_d.coef_load = 1'b0;
    end
    // boot results are status, so soft reset leaves them alone
    if (boot_done) begin
      st_d.csum = boot_csum;
      st_d.bstat = {~boot_timeout & ~boot_match, ~boot_timeout & boot_match,
                    ~boot_timeout};
    end
    // 3-wire reads turn the data pin around; 4-wire reads use the output pin when dig_pin enables it and the mixer does not put the reference clock there
    st_d.sdio_oe_n = ~(st_q.phase == dcr_pkg::DCR_DATA && st_q.rd && !pins.cs_n &&
                       !st_q.setup[`DCR_B_4W]);
    if (st_q.cfg.mixer[`DCR_B_RCLK_SEL]) begin
      st_d.sdo_out = rclk_in;
      st_d.sdo_oe_n = ~st_q.cfg.dig_pin[`DCR_B_PIN_OE];
    end else begin
      st_d.sdo_out = st_d.dout;
      st_d.sdo_oe_n = ~(st_q.phase == dcr_pkg::DCR_DATA && st_q.rd && !pins.cs_n &&
                        st_q.setup[`DCR_B_4W] && st_q.cfg.dig_pin[`DCR_B_PIN_OE]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= RST_ST;
    end else begin
      st_q <= st_d;
    end
  end

  assign sdio_out = st_q.dout;
  assign sdio_oe_n = st_q.sdio_oe_n;
  assign sdo_out = st_q.sdo_out;
  assign sdo_oe_n = st_q.sdo_oe_n;
  assign soft_reset = st_q.setup[`DCR_B_SRST];
  assign cfg = st_q.cfg;
  assign coef_active = st_q.coef_act;
  assign coef_load = st_q.coef_load;

  // ==========================================================================
  // checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_srst_enter;
    wr_en && st_q.addr == `DCR_A_SETUP && (wr_data[7] || wr_data[0]) |=> soft_reset;
  endproperty
  a_srst_enter: assert property (p_srst_enter) else $error("soft reset not entered");

  property p_srst_hold;
    soft_reset && !(wr_en && st_q.addr == `DCR_A_SETUP) |=> soft_reset;
  endproperty
  a_srst_hold: assert property (p_srst_hold) else $error("soft reset dropped");

  property p_srst_dflt;
    soft_reset |-> st_q.cfg == RST_ST.cfg && st_q.coef == RST_ST.coef && st_q.strobe == 2'b00;
  endproperty
  a_srst_dflt: assert property (p_srst_dflt) else $error("register off default in reset");

  property p_order;
    pins.sclk_rise && !pins.cs_n && !boot_busy |=>
      ($past(st_q.setup[`DCR_B_LSB]) ? st_q.sr[15] : st_q.sr[0]) == $past(pins.sdi);
  endproperty
  a_order: assert property (p_order) else $error("serial bit landed in wrong end");

  property p_step;
    byte_done |=> st_q.addr == ($past(st_q.setup[`DCR_B_INC]) ?
      15'($past(st_q.addr) + 15'h0001) : 15'($past(st_q.addr) - 15'h0001));
  endproperty
  a_step: assert property (p_step) else $error("address stepped wrongly");

  property p_wire_mode;
    (!sdio_oe_n |-> !$past(st_q.setup[`DCR_B_4W])) and
    (!sdo_oe_n && !$past(st_q.cfg.mixer[`DCR_B_RCLK_SEL]) |-> $past(st_q.setup[`DCR_B_4W]));
  endproperty
  a_wire_mode: assert property (p_wire_mode) else $error("pin driven in wrong wire mode");

  property p_mirror;
    rd_reg(st_q, `DCR_A_SETUP) ==
      {st_q.setup, st_q.setup[0], st_q.setup[1], st_q.setup[2], st_q.setup[3]};
  endproperty
  a_mirror: assert property (p_mirror) else $error("setup mirror broken");

  property p_load;
    coef_load |-> coef_active == st_q.coef && $past(st_q.strobe) == 2'b00 && st_q.strobe != 2'b00;
  endproperty
  a_load: assert property (p_load) else $error("coefficient load mismatch");

  property p_rclk;
    st_q.cfg.mixer[`DCR_B_RCLK_SEL] && st_q.cfg.dig_pin[`DCR_B_PIN_OE] |=>
      !sdo_oe_n && sdo_out == $past(rclk_in);
  endproperty
  a_rclk: assert property (p_rclk) else $error("reference clock not on pin");

  property p_boot;
    boot_done |=> st_q.csum == $past(boot_csum) && st_q.bstat[0] == !$past(boot_timeout) &&
      st_q.bstat[1] == ($past(boot_match) && !$past(boot_timeout));
  endproperty
  a_boot: assert property (p_boot) else $error("boot result not recorded");

  property p_ro;
    wr_en && (st_q.addr == `DCR_A_CSUM || st_q.addr == `DCR_A_BSTAT) && !boot_done |=>
      $stable(st_q.csum) && $stable(st_q.bstat);
  endproperty
  a_ro: assert property (p_ro) else $error("read-only register changed");

  c_read: cover property (byte_done && st_q.rd);
  c_write: cover property (wr_en && is_coef(st_q.addr));
  c_load: cover property (coef_load);
  c_srst: cover property (soft_reset ##1 !soft_reset);

endmodule // dcr_config_bank

/* File: design/dcr_consts.svh */
// addresses, field positions, field masks and reset values of the configuration bank
// assumes a 15-bit register address, as carried by the serial instruction word
`ifndef DCR_CONSTS_SVH
`define DCR_CONSTS_SVH

// ==========================================================================
// register addresses
`define DCR_A_SETUP 15'h0000
`define DCR_A_REV 15'h0006
`define DCR_A_STROBE 15'h0010
`define DCR_A_COEF_LO 15'h0011
`define DCR_A_COEF_HI 15'h0027
`define DCR_A_APIN 15'h0028
`define DCR_A_SYNC 15'h0029
`define DCR_A_MIX 15'h002a
`define DCR_A_CLK 15'h002b
`define DCR_A_DPIN 15'h002c
`define DCR_A_CORE 15'h002d
`define DCR_A_CSUM 15'h002e
`define DCR_A_BSTAT 15'h002f
`define DCR_N_COEF 23

// ==========================================================================
// field positions inside the stored setup nibble (upper half of the setup byte), the mixer byte and the digital pin byte
`define DCR_B_SRST 3
`define DCR_B_LSB 2
`define DCR_B_INC 1
`define DCR_B_4W 0
`define DCR_B_RCLK_SEL 3
`define DCR_B_PIN_OE 0

// ==========================================================================
// writable-bit masks; all other bits read as zero
`define DCR_M_STROBE 8'h03
`define DCR_M_APIN 8'h03
`define DCR_M_SYNC 8'h3f
`define DCR_M_MIX 8'h58
`define DCR_M_CLK 8'h1f
`define DCR_M_DPIN 8'h01
`define DCR_M_CORE 8'h01

// ==========================================================================
// reset values; coefficient bytes packed with address 0x11 in the low byte
`define DCR_R_APIN 8'h00
`define DCR_R_SYNC 8'h2d
`define DCR_R_MIX 8'h18
`define DCR_R_CLK 8'h02
`define DCR_R_DPIN 8'h01
`define DCR_R_CORE 8'h00
`define DCR_R_COEF 184'h000000e0000fc00fc00fc0887e971d0fc00fc0d71d0fc0

`endif

/* File: design/dcr_pin_sync.sv */
// two-stage synchroniser for the serial pins plus serial clock edge detection
// assumes the serial clock is well below half of sys_clk
`timescale 1ns/1ps
`include "dcr_consts.svh"

module dcr_pin_sync (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic sdi_pin,
  output dcr_pkg::dcr_pins_s pins
);

  dcr_pkg::dcr_sync_s st_q;
  dcr_pkg::dcr_sync_s st_d;

  // ==========================================================================
  // stage shift; edges look only at the second stage, never the first
  always_comb begin
    st_d = st_q;
    st_d.m = {sclk_pin, cs_n_pin, sdi_pin};
    st_d.s = st_q.m;
    st_d.sclk_prev = st_q.s[2];
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '{m: 3'h2, s: 3'h2, sclk_prev: 1'b0}; // chip select idles high
    end else begin
      st_q <= st_d;
    end
  end

  assign pins.sclk_rise = st_q.s[2] & ~st_q.sclk_prev;
  assign pins.sclk_fall = ~st_q.s[2] & st_q.sclk_prev;
  assign pins.cs_n = st_q.s[1];
  assign pins.sdi = st_q.s[0];

endmodule // dcr_pin_sync

/* File: design/dcr_pkg.sv */
// types shared by the configuration bank modules
// assumes dcr_consts.svh is on the include path
`include "dcr_consts.svh"

package dcr_pkg;

  // ==========================================================================
  // serial frame phase, gray coded along idle -> instruction -> data
  typedef enum logic [1:0] {
    DCR_IDLE = 2'b00,
    DCR_INSTR = 2'b01,
    DCR_DATA = 2'b11
  } dcr_phase_e;

  // synchronised serial pins and clock edges
  typedef struct packed {
    logic sclk_rise;
    logic sclk_fall;
    logic cs_n;
    logic sdi;
  } dcr_pins_s;

  // synchroniser state: first stage, second stage, previous serial clock
  typedef struct packed {
    logic [2:0] m;
    logic [2:0] s;
    logic sclk_prev;
  } dcr_sync_s;

  // configuration bytes driven to the analog core
  typedef struct packed {
    logic [7:0] analog_pin;
    logic [7:0] sync_out;
    logic [7:0] mixer;
    logic [7:0] clk_div;
    logic [7:0] dig_pin;
    logic [7:0] core_rst;
  } dcr_cfg_s;

  // whole state of the register bank
  typedef struct packed {
    dcr_phase_e phase;
    logic [3:0] bit_cnt;
    logic [15:0] sr;
    logic [14:0] addr;
    logic rd;
    logic [7:0] tx;
    logic [3:0] setup;
    logic [1:0] strobe;
    logic [`DCR_N_COEF*8-1:0] coef;
    logic [`DCR_N_COEF*8-1:0] coef_act;
    logic coef_load;
    dcr_cfg_s cfg;
    logic [7:0] csum;
    logic [2:0] bstat;
    logic dout;
    logic sdio_oe_n;
    logic sdo_out;
    logic sdo_oe_n;
  } dcr_core_s;

endpackage

/* File: test/dcrh_spi_host.sv */
// serial host model that configures the register bank over its pins
// assumes sys_clk of the bench; serial clock idles low and stands still outside frames
`timescale 1ns/1ps

module dcrh_spi_host (
  input wire logic sys_clk,
  output logic sclk_pin,
  output logic cs_n_pin,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  input wire logic sdo_out,
  input wire logic sdo_oe_n
);
  logic drv;
  logic bit_q;
  logic lsb;
  logic four_wire;

  // ==========================================================================
  // pin levels
  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    drv = 1'b1;
    bit_q = 1'b1;
    lsb = 1'b0;
    four_wire = 1'b0;
  end

  // a released line shows the inverse of the last bit, never a stale copy
  assign sdio_in = !sdio_oe_n ? sdio_out : (drv ? bit_q : ~bit_q);

  // ==========================================================================
  // bit and frame tasks
  // half of a serial clock period, six sys_clk cycles to stay above the minimum of three
  task automatic half();
    repeat (6) @(posedge sys_clk);
  endtask

  // data changes while sclk is low, sampled by both sides on the rising edge
  task automatic shift(input int n, input logic [15:0] v, input logic rel,
                       output logic [15:0] got);
    int idx;
    got = '0;
    for (int i = 0; i < n; i++) begin
      idx = lsb ? i : n - 1 - i;
      drv <= !rel;
      if (!rel) bit_q <= v[idx];
      half();
      got[idx] = four_wire ? sdo_out : sdio_in;
      sclk_pin <= 1'b1;
      half();
      sclk_pin <= 1'b0;
    end
  endtask

  // one whole frame: instruction, then nb data bytes; partial bytes are never sent
  task automatic frame(input logic [15:0] ins, input int nb, input logic [7:0] wd [4],
                       output logic [7:0] rd [4]);
    logic [15:0] g;
    cs_n_pin <= 1'b0;
    half();
    shift(16, ins, 1'b0, g);
    for (int b = 0; b < nb; b++) begin
      shift(8, {8'h00, wd[b]}, ins[15] && !four_wire, g);
      rd[b] = g[7:0];
    end
    half();
    cs_n_pin <= 1'b1;
    drv <= 1'b1;
    half();
  endtask
endmodule // dcrh_spi_host

/* File: test/tb.sv */
// self-checking bench of the configuration register bank
// assumes the serial host model and the design files are compiled before it
`timescale 1ns/1ps
`include "dcr_consts.svh"

module tb;
  localparam logic [3:0] REV = 4'h9; // arbitrary revision value
  logic sys_clk, srst, sclk_pin, cs_n_pin, sdio_in, sdio_out, sdio_oe_n, sdo_out, sdo_oe_n;
  logic rclk_in, boot_busy, boot_done, boot_timeout, boot_match, soft_reset, coef_load;
  logic oe_bad;
  logic [7:0] boot_csum;
  logic [7:0] v;
  dcr_pkg::dcr_cfg_s cfg;
  logic [`DCR_N_COEF*8-1:0] coef_active;
  logic [7:0] wd [4];
  logic [7:0] rd [4];
  int n_errors, n_tests, cycles, n_load;

  dcr_config_bank #(.DIE_REV(REV)) uut (.sys_clk(sys_clk), .srst(srst), .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .rclk_in(rclk_in), .boot_busy(boot_busy),
    .boot_done(boot_done), .boot_timeout(boot_timeout), .boot_match(boot_match),
    .boot_csum(boot_csum), .soft_reset(soft_reset), .cfg(cfg), .coef_active(coef_active),
    .coef_load(coef_load));

  dcrh_spi_host host (.sys_clk(sys_clk), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n));

  // ==========================================================================
  // clock, hang guard and monitors
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // a one-byte frame costs 306 cycles and the run has 43 frames, two of them two-byte
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      close_out();
    end
    if (coef_load === 1'b1) n_load++;
    if (host.four_wire && sdio_oe_n !== 1'b1) oe_bad <= 1'b1;
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    wd[0] = d;
    host.frame({1'b0, a}, 1, wd, rd);
  endtask

  task automatic rchk(input string name, input logic [14:0] a, input logic [7:0] exp);
    host.frame({1'b1, a}, 1, wd, rd);
    chk(name, rd[0], exp);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  // reset values at the ports and through reads, unmapped place reads zero
  task automatic t_defaults();
    logic [7:0] dflt [6] = '{8'h00, 8'h2d, 8'h18, 8'h02, 8'h01, 8'h00};
    chk("cfg", cfg.sync_out, 8'h2d);
    for (int i = 0; i < 6; i++) rchk("default", 15'h0028 + 15'(i), dflt[i]);
    rchk("revision", `DCR_A_REV, {4'h0, REV});
    rchk("unmapped", 15'h0001, 8'h00);
    chk("sdio idle", {7'h0, sdio_oe_n}, 8'h01);
  endtask

  // read-only places keep their values, don't-care bits read zero
  task automatic t_readonly();
    wr(`DCR_A_CSUM, 8'hff);
    wr(`DCR_A_BSTAT, 8'hff);
    wr(`DCR_A_REV, 8'hff);
    rchk("checksum", `DCR_A_CSUM, 8'h00);
    rchk("status", `DCR_A_BSTAT, 8'h00);
    rchk("revision", `DCR_A_REV, {4'h0, REV});
    wr(`DCR_A_MIX, 8'hff);
    rchk("mixer", `DCR_A_MIX, 8'h58);
    wr(`DCR_A_MIX, 8'h18);
  endtask

  // soft reset holds defaults, ignores writes meanwhile, and ends on a zero write
  task automatic t_soft_reset();
    wr(`DCR_A_CLK, 8'h1f);
    wr(`DCR_A_SETUP, 8'h80);
    chk("soft_reset", {7'h0, soft_reset}, 8'h01);
    chk("clk_div", cfg.clk_div, 8'h02);
    rchk("setup", `DCR_A_SETUP, 8'h81);
    wr(`DCR_A_CLK, 8'h05);
    wr(`DCR_A_SETUP, 8'h00);
    chk("soft_reset", {7'h0, soft_reset}, 8'h00);
    rchk("clk_div", `DCR_A_CLK, 8'h02);
  endtask

  // reference clock on the shared pin follows the on-chip clock
  task automatic t_rclk();
    chk("sdo_oe_n", {7'h0, sdo_oe_n}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      rclk_in <= !i[0];
      repeat (3) @(posedge sys_clk);
      chk("sdo_out", {7'h0, sdo_out}, {7'h0, !i[0]});
    end
  endtask

  // multibyte writes step the address up, then down
  task automatic t_addr_dir();
    wr(`DCR_A_SETUP, 8'h20);
    rchk("setup", `DCR_A_SETUP, 8'h24);
    wd = '{8'h01, 8'h05, 8'h00, 8'h00};
    host.frame({1'b0, `DCR_A_APIN}, 2, wd, rd);
    chk("analog_pin", cfg.analog_pin, 8'h01);
    chk("sync_out", cfg.sync_out, 8'h05);
    wr(`DCR_A_SETUP, 8'h00);
    wd = '{8'h07, 8'h10, 8'h00, 8'h00};
    host.frame({1'b0, `DCR_A_CLK}, 2, wd, rd);
    chk("clk_div", cfg.clk_div, 8'h07);
    chk("mixer", cfg.mixer, 8'h10);
  endtask

  // least significant bit first in both directions
  task automatic t_lsb();
    wr(`DCR_A_SETUP, 8'h40);
    host.lsb = 1'b1;
    rchk("lsb read", `DCR_A_CLK, 8'h07);
    wr(`DCR_A_SYNC, 8'h31);
    chk("lsb write", cfg.sync_out, 8'h31);
    wr(`DCR_A_SETUP, 8'h00);
    host.lsb = 1'b0;
    rchk("msb read", `DCR_A_SYNC, 8'h31);
  endtask

  // four-wire reads come on the output pin while the data pin stays input
  task automatic t_four_wire();
    wr(`DCR_A_SETUP, 8'h10);
    host.four_wire = 1'b1;
    oe_bad = 1'b0;
    rchk("four wire", `DCR_A_CLK, 8'h07);
    wr(`DCR_A_SETUP, 8'h00);
    host.four_wire = 1'b0;
    chk("sdio enable", {7'h0, oe_bad}, 8'h00);
  endtask

  // a strobe rising from zero loads once; nonzero to nonzero does not reload
  task automatic t_strobe();
    wr(`DCR_A_COEF_LO, 8'ha5);
    wr(`DCR_A_COEF_HI, 8'h3c);
    n_load = 0;
    wr(`DCR_A_STROBE, 8'h01);
    chk("loads", 8'(n_load), 8'h01);
    chk("coef first", coef_active[7:0], 8'ha5);
    chk("coef last", coef_active[183:176], 8'h3c);
    wr(`DCR_A_STROBE, 8'h02);
    chk("loads", 8'(n_load), 8'h01);
  endtask

  // boot results show in the checksum and status places
  task automatic t_boot();
    boot_csum <= 8'h5a;
    boot_match <= 1'b1;
    boot_done <= 1'b1;
    @(posedge sys_clk);
    boot_done <= 1'b0;
    rchk("checksum", `DCR_A_CSUM, 8'h5a);
    rchk("status", `DCR_A_BSTAT, 8'h03);
    boot_match <= 1'b0;
    boot_timeout <= 1'b1;
    boot_done <= 1'b1;
    @(posedge sys_clk);
    boot_done <= 1'b0;
    host.frame({1'b1, `DCR_A_BSTAT}, 1, wd, rd);
    chk("status bit0", rd[0] & 8'h01, 8'h00);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    srst = 1'b1;
    rclk_in = 1'b0;
    boot_busy = 1'b0;
    boot_done = 1'b0;
    boot_timeout = 1'b0;
    boot_match = 1'b0;
    boot_csum = 8'h00;
    oe_bad = 1'b0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    t_defaults();
    t_readonly();
    t_soft_reset();
    t_rclk();
    t_addr_dir();
    t_lsb();
    t_four_wire();
    t_strobe();
    t_boot();
    close_out();
  end
endmodule // tb
